// >>> logic/bpm_defs.vh
// constants for the block protection bit map
`ifndef BPM_DEFS_VH
`define BPM_DEFS_VH

`define BPM_ADDR_W 24
`define BPM_BIT_W 9
`define BPM_SECT_LAST 3'h4

`define BPM_BYTE_TYPE 2'h0
`define BPM_BYTE_COUNT 2'h1
`define BPM_BYTE_START 2'h2
`define BPM_BYTE_END 2'h3

`define BPM_TYPE_1 8'h01
`define BPM_TYPE_8K 8'h02
`define BPM_TYPE_32K 8'h03
`define BPM_TYPE_64K 8'h04

`define BPM_SIZE_ADDR_1 8'h4c
`define BPM_SIZE_ADDR_2 8'h4e
`define BPM_SIZE_ADDR_3 8'h50
`define BPM_SIZE_ADDR_4 8'h52

`define BPM_N_8K 8'h02
`define BPM_N_32K 8'h00

`define BPM_ZERO_ADDER 8'h00
`define BPM_C_BOT_START 8'hff
`define BPM_C_BOT_END 8'h04
`define BPM_C_LO32 8'hfd
`define BPM_C_64_START 8'h00
`define BPM_C_64_END 8'hfc
`define BPM_C_HI32 8'hfe
`define BPM_C_TOP_START 8'h07
`define BPM_C_TOP_END 8'h0e

`define BPM_M_MIN 4'h4
`define BPM_M_MAX 4'h8

`define BPM_SZ_32K 25'h0008000
`define BPM_SZ_64K 25'h0010000

`endif

// >>> logic/bpm_desc_rom.v
// descriptor byte table with registered read data
`include "bpm_defs.vh"

module bpm_desc_rom (
    input wire clk,
    input wire rst_n,
    input wire clk_en,
    input wire rd_en,
    input wire [4:0] rd_idx,
    input wire [3:0] density_m,
    output reg [7:0] rd_data
);

    reg [7:0] next_data;

    // index is section times four plus byte number
    always @* begin
        case (rd_idx)
            5'h00: next_data = `BPM_TYPE_8K;
            5'h01: next_data = `BPM_N_8K;
            5'h02: next_data = `BPM_C_BOT_START;
            5'h03: next_data = `BPM_C_BOT_END;
            5'h04: next_data = `BPM_TYPE_32K;
            5'h05: next_data = `BPM_N_32K;
            5'h06: next_data = `BPM_C_LO32;
            5'h07: next_data = `BPM_C_LO32;
            5'h08: next_data = `BPM_TYPE_64K;
            5'h09: next_data = {4'h0, density_m};
            5'h0a: next_data = `BPM_C_64_START;
            5'h0b: next_data = `BPM_C_64_END;
            5'h0c: next_data = `BPM_TYPE_32K;
            5'h0d: next_data = `BPM_N_32K;
            5'h0e: next_data = `BPM_C_HI32;
            5'h0f: next_data = `BPM_C_HI32;
            5'h10: next_data = `BPM_TYPE_8K;
            5'h11: next_data = `BPM_N_8K;
            5'h12: next_data = `BPM_C_TOP_START;
            5'h13: next_data = `BPM_C_TOP_END;
            default: next_data = 8'h00;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else if (clk_en && rd_en) begin
            rd_data <= next_data;
        end
    end

endmodule // bpm_desc_rom

// >>> logic/bpm_bit_calc.v
// protection bit position from a signed adder byte
`include "bpm_defs.vh"

module bpm_bit_calc (
    input wire [3:0] density_m,
    input wire [7:0] adder,
    input wire [8:0] step,
    output wire [8:0] bit_pos
);

    // 11 bits hold 2^8 + 1 + 14 plus any step without wrap
    wire [10:0] pow = 11'h001 << density_m;
    wire [10:0] ext = {{3{adder[7]}}, adder};
    wire [10:0] anchor;
    wire [10:0] sum;

    assign anchor = (adder == `BPM_ZERO_ADDER) ? 11'h000 :
        pow + 11'h001 + ext;
    assign sum = anchor + {2'h0, step};
    assign bit_pos = sum[8:0];

endmodule // bpm_bit_calc

// >>> logic/bpm_map.v
// block protection bit map: descriptor reads, scan and address lookup
`include "bpm_defs.vh"

module bpm_map (
    input wire clk,
    input wire rst_n,
    input wire clk_en,
    input wire [3:0] density_m,
    output reg m_ok,
    input wire rd_req,
    input wire [2:0] rd_sect,
    input wire [1:0] rd_byte,
    output wire rd_busy,
    output reg rd_valid,
    output reg rd_err,
    output wire [7:0] rd_data,
    input wire lk_req,
    input wire [23:0] lk_addr,
    output reg lk_valid,
    output reg lk_err,
    output reg [2:0] lk_sect,
    output reg [7:0] lk_type,
    output reg [7:0] lk_block,
    output reg lk_rd_lock,
    output reg [8:0] lk_wr_bit,
    output reg [8:0] lk_rd_bit,
    input wire scan_start,
    output reg scan_busy,
    output reg sc_valid,
    output reg [2:0] sc_sect,
    output reg [7:0] sc_type,
    output reg [8:0] sc_count,
    output reg [8:0] sc_first_bit,
    output reg [8:0] sc_last_bit,
    output reg scan_done
);

    // scan: one issue and one wait per byte, one emit per section
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ISSUE = 2'h1;
    localparam [1:0] ST_WAIT = 2'h2;
    localparam [1:0] ST_EMIT = 2'h3;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [2:0] scan_sect;
    reg [1:0] scan_byte;
    reg [7:0] cap_type;
    reg [7:0] cap_count;
    reg [7:0] cap_start;
    reg [7:0] cap_end;

    wire m_in_range;
    wire host_take;
    wire scan_issue;
    wire rom_rd_en;
    wire [4:0] rom_idx;
    wire [7:0] rom_data;

    // the 5-bit index covers sections 0 to 7 times four bytes
    wire [4:0] host_idx = {rd_sect, rd_byte};
    wire [4:0] scan_idx = {scan_sect, scan_byte};

    // m outside 4..8 turns every lookup into an error
    assign m_in_range = (density_m >= `BPM_M_MIN) &&
        (density_m <= `BPM_M_MAX);

    // scan owns the table while it runs; host reads are refused then
    assign rd_busy = scan_busy;
    assign host_take = rd_req && !scan_busy;
    assign scan_issue = (state == ST_ISSUE);
    assign rom_rd_en = host_take || scan_issue;
    assign rom_idx = scan_issue ? scan_idx : host_idx;
    assign rd_data = rom_data;

    bpm_desc_rom u_rom (
        .clk(clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .rd_en(rom_rd_en),
        .rd_idx(rom_idx),
        .density_m(density_m),
        .rd_data(rom_data)
    );

    // ---- address lookup decode ----
    wire [24:0] addr_ext = {1'b0, lk_addr};
    // the upper section edges move with the array top, which scales with m; the 32K and 64K edges are fixed
    wire [24:0] top = `BPM_SZ_64K << density_m;
    wire [24:0] top_lo64 = top - `BPM_SZ_64K;
    wire [24:0] top_lo32 = top - `BPM_SZ_32K;

    reg [2:0] dec_sect;
    reg [7:0] dec_type;
    reg [7:0] dec_block;
    reg [7:0] dec_adder;
    reg dec_err;
    reg dec_8k;

    // sections in address order from zero
    always @* begin
        dec_err = 1'b0;
        dec_sect = 3'h0;
        dec_type = `BPM_TYPE_8K;
        dec_block = 8'h00;
        dec_adder = `BPM_C_BOT_START;
        dec_8k = 1'b0;
        if (!m_in_range || addr_ext >= top) begin
            dec_err = 1'b1;
        end else if (addr_ext < `BPM_SZ_32K) begin
            dec_sect = 3'h0;
            dec_type = `BPM_TYPE_8K;
            dec_block = {6'h00, lk_addr[14:13]};
            dec_adder = `BPM_C_BOT_START;
            dec_8k = 1'b1;
        end else if (addr_ext < `BPM_SZ_64K) begin
            dec_sect = 3'h1;
            dec_type = `BPM_TYPE_32K;
            dec_block = 8'h00;
            dec_8k = 1'b0;
            dec_adder = `BPM_C_LO32;
        end else if (addr_ext < top_lo64) begin
            dec_sect = 3'h2;
            dec_type = `BPM_TYPE_64K;
            // the first 64K block sits just above the lower 32K block
            dec_block = lk_addr[23:16] - 8'h01;
            dec_8k = 1'b0;
            dec_adder = `BPM_C_64_START;
        end else if (addr_ext < top_lo32) begin
            dec_sect = 3'h3;
            dec_type = `BPM_TYPE_32K;
            dec_block = 8'h00;
            dec_8k = 1'b0;
            dec_adder = `BPM_C_HI32;
        end else begin
            dec_sect = 3'h4;
            dec_type = `BPM_TYPE_8K;
            dec_block = {6'h00, lk_addr[14:13]};
            dec_adder = `BPM_C_TOP_START;
            dec_8k = 1'b1;
        end
    end

    // 8K blocks own a write/read pair, so their step is doubled
    wire [8:0] dec_step = dec_8k ? {dec_block, 1'b0} :
        {1'b0, dec_block};

    // ---- bit calculators: lookup, scan first, scan last ----
    wire [23:0] calc_adder = {cap_end, cap_start, dec_adder};
    wire [26:0] calc_step = {9'h000, 9'h000, dec_step};
    wire [26:0] calc_pos;

    // three lanes share one adder form so scan and lookup agree
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_calc
            bpm_bit_calc u_calc (
                .density_m(density_m),
                .adder(calc_adder[gi*8 +: 8]),
                .step(calc_step[gi*9 +: 9]),
                .bit_pos(calc_pos[gi*9 +: 9])
            );
        end
    endgenerate

    // lane 0 serves lookups, lanes 1 and 2 the scan's start and end
    wire [8:0] lk_pos = calc_pos[8:0];
    wire [8:0] scan_first = calc_pos[17:9];
    wire [8:0] scan_last = calc_pos[26:18];

    // count byte is an exponent; 64K form subtracts the two 32K slots
    wire [8:0] cnt_pow = 9'h001 << cap_count[3:0];
    wire [8:0] scan_cnt = (cap_type == `BPM_TYPE_64K) ?
        cnt_pow - 9'h002 : cnt_pow;

    // ---- scan state machine ----
    always @* begin
        case (state)
            ST_IDLE: next_state = scan_start ? ST_ISSUE : ST_IDLE;
            ST_ISSUE: next_state = ST_WAIT;
            ST_WAIT: begin
                // four bytes per section before the emit cycle
                if (scan_byte == `BPM_BYTE_END) begin
                    next_state = ST_EMIT;
                end else begin
                    next_state = ST_ISSUE;
                end
            end
            ST_EMIT: begin
                if (scan_sect == `BPM_SECT_LAST) begin
                    next_state = ST_IDLE;
                end else begin
                    next_state = ST_ISSUE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            scan_sect <= 3'h0;
            scan_byte <= 2'h0;
            scan_busy <= 1'b0;
            scan_done <= 1'b0;
            sc_valid <= 1'b0;
            sc_sect <= 3'h0;
            sc_type <= 8'h00;
            sc_count <= 9'h000;
            sc_first_bit <= 9'h000;
            sc_last_bit <= 9'h000;
        end else if (clk_en) begin
            state <= next_state;
            sc_valid <= 1'b0;
            scan_done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (scan_start) begin
                        scan_busy <= 1'b1;
                        scan_sect <= 3'h0;
                        scan_byte <= 2'h0;
                    end
                end
                ST_WAIT: begin
                    scan_byte <= scan_byte + 2'h1;
                end
                ST_EMIT: begin
                    sc_valid <= 1'b1;
                    sc_sect <= scan_sect;
                    sc_type <= cap_type;
                    sc_count <= scan_cnt;
                    sc_first_bit <= scan_first;
                    sc_last_bit <= scan_last;
                    scan_byte <= 2'h0;
                    // busy drops only here, so host reads wait the whole walk
                    if (scan_sect == `BPM_SECT_LAST) begin
                        scan_busy <= 1'b0;
                        scan_done <= 1'b1;
                    end else begin
                        scan_sect <= scan_sect + 3'h1;
                    end
                end
                default: begin
                    scan_busy <= scan_busy;
                end
            endcase
        end
    end

    // bytes arrive in descriptor order, one per wait cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_type <= 8'h00;
            cap_count <= 8'h00;
            cap_start <= 8'h00;
            cap_end <= 8'h00;
        end else if (clk_en && state == ST_WAIT) begin
            case (scan_byte)
                `BPM_BYTE_TYPE: cap_type <= rom_data;
                `BPM_BYTE_COUNT: cap_count <= rom_data;
                `BPM_BYTE_START: cap_start <= rom_data;
                default: cap_end <= rom_data;
            endcase
        end
    end

    // ---- host descriptor read answer ----
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid <= 1'b0;
            rd_err <= 1'b0;
        end else if (clk_en) begin
            rd_valid <= host_take;
            // sections beyond the last read back as zero with an error
            rd_err <= host_take && (rd_sect > `BPM_SECT_LAST);
        end
    end

    // ---- lookup answer ----
    // even anchor: write bit even, read bit the odd one above
    wire [8:0] lk_pair_bit = dec_8k ? lk_pos + 9'h001 : lk_pos;

    // valid follows the request on every enabled edge; fields hold until the next request
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lk_valid <= 1'b0;
        end else if (clk_en) begin
            lk_valid <= lk_req;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lk_err <= 1'b0;
            lk_sect <= 3'h0;
            lk_type <= 8'h00;
            lk_block <= 8'h00;
            lk_rd_lock <= 1'b0;
            lk_wr_bit <= 9'h000;
            lk_rd_bit <= 9'h000;
        end else if (clk_en && lk_req) begin
            lk_err <= dec_err;
            lk_sect <= dec_sect;
            lk_type <= dec_type;
            lk_block <= dec_block;
            lk_rd_lock <= dec_8k && !dec_err;
            lk_wr_bit <= lk_pos;
            lk_rd_bit <= lk_pair_bit;
        end
    end

    // range flag kept apart so a bad m shows even with no lookup
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            m_ok <= 1'b0;
        end else if (clk_en) begin
            m_ok <= m_in_range;
        end
    end

endmodule // bpm_map

// >>> tb/bpm_map_sva.sv
// assertions on the bit map ports
module bpm_map_sva (
    input wire clk,
    input wire rst_n,
    input wire clk_en,
    input wire [3:0] density_m,
    input wire m_ok,
    input wire rd_req,
    input wire [2:0] rd_sect,
    input wire [1:0] rd_byte,
    input wire rd_busy,
    input wire rd_valid,
    input wire [7:0] rd_data,
    input wire lk_req,
    input wire lk_valid,
    input wire lk_err,
    input wire lk_rd_lock,
    input wire [8:0] lk_wr_bit,
    input wire [8:0] lk_rd_bit,
    input wire scan_busy,
    input wire sc_valid,
    input wire [2:0] sc_sect,
    input wire [7:0] sc_type,
    input wire [8:0] sc_count,
    input wire [8:0] sc_first_bit,
    input wire [8:0] sc_last_bit,
    input wire scan_done
);
timeunit 1ns;
timeprecision 100ps;
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
wire rd_take = rd_req && !rd_busy && clk_en;
a_rd_answer: assert property (rd_take |=> rd_valid)
    else $error("read not answered");
a_rd_refused: assert property (rd_req && rd_busy |=> !rd_valid)
    else $error("read answered while busy");
a_count_sixty4k: assert property (rd_take && m_ok && rd_sect == 3'h2
    && rd_byte == 2'h1 |=> rd_data == {4'h0, density_m})
    else $error("64k count byte wrong");
a_lk_answer: assert property (lk_req && clk_en |=> lk_valid)
    else $error("lookup not answered");
a_lk_pair: assert property (lk_valid && !lk_err
    |-> lk_rd_bit == lk_wr_bit + {8'h00, lk_rd_lock})
    else $error("read lock bit not next to write bit");
a_lk_even: assert property (lk_valid && !lk_err && lk_rd_lock
    |-> !lk_wr_bit[0])
    else $error("write lock bit odd");
a_scan_first: assert property ($rose(scan_busy) |-> ##9 sc_valid)
    else $error("first section late");
a_done_last: assert property (scan_done |-> sc_valid && sc_sect == 3'h4)
    else $error("done not with last section");
a_count_m: assert property (sc_valid && sc_type == 8'h04
    |-> sc_count == (9'h1 << density_m) - 9'h2)
    else $error("64k block count wrong");
a_span_count: assert property (sc_valid && sc_type != 8'h02
    |-> sc_last_bit - sc_first_bit + 9'h1 == sc_count)
    else $error("bit span differs from count");
c_done: cover property (scan_done);
c_refused: cover property (rd_req && rd_busy);
c_lk_err: cover property (lk_valid && lk_err);
endmodule // bpm_map_sva

bind bpm_map bpm_map_sva i_bpm_map_sva (.clk, .rst_n, .clk_en, .density_m,
    .m_ok, .rd_req, .rd_sect, .rd_byte, .rd_busy, .rd_valid, .rd_data,
    .lk_req, .lk_valid, .lk_err, .lk_rd_lock, .lk_wr_bit, .lk_rd_bit,
    .scan_busy, .sc_valid, .sc_sect, .sc_type, .sc_count, .sc_first_bit,
    .sc_last_bit, .scan_done);

// >>> tb/bpm_host.sv
// host model that fetches descriptor bytes
module bpm_host (
    input wire clk,
    input wire rd_busy,
    input wire rd_valid,
    input wire rd_err,
    input wire [7:0] rd_data,
    output logic rd_req,
    output logic [2:0] rd_sect,
    output logic [1:0] rd_byte
);
timeunit 1ns;
timeprecision 100ps;
initial begin
    rd_req = 1'h0;
    rd_sect = 3'h0;
    rd_byte = 2'h0;
end
// request stays up so reads can run back to back
task automatic read(input logic [2:0] s, input logic [1:0] b,
    input logic wait_free, output logic [7:0] d, output logic e, v);
    while (wait_free && rd_busy) begin
        @(posedge clk);
        #2;
    end
    rd_req = 1'h1;
    rd_sect = s;
    rd_byte = b;
    @(posedge clk);
    #2;
    d = rd_data;
    e = rd_err;
    v = rd_valid;
endtask
// released lines show junk, never the last value
task automatic idle();
    rd_req = 1'h0;
    rd_sect = ~rd_sect;
    rd_byte = ~rd_byte;
endtask
endmodule // bpm_host

// >>> tb/bpm_map_tb.sv
// self-checking bench for the block protection bit map
module bpm_map_tb;
timeunit 1ns;
timeprecision 100ps;
logic clk = 1'h0, rst_n = 1'h0, clk_en = 1'h1, lk_req = 1'h0;
logic scan_start = 1'h0;
logic [3:0] density_m = 4'h6;
logic [23:0] lk_addr = 24'h0;
wire rd_req, rd_busy, rd_valid, rd_err, m_ok, lk_valid, lk_err;
wire lk_rd_lock, scan_busy, sc_valid, scan_done;
wire [2:0] rd_sect, lk_sect, sc_sect;
wire [1:0] rd_byte;
wire [7:0] rd_data, lk_type, lk_block, sc_type;
wire [8:0] lk_wr_bit, lk_rd_bit, sc_count, sc_first_bit, sc_last_bit;
int error_cnt = 0, n_checks = 0;
logic [7:0] d;
logic e, v;
// type, count, start adder, end adder per section; 64k count is m
logic [7:0] tab [0:19] = '{8'h02, 8'h02, 8'hff, 8'h04, 8'h03, 8'h00,
    8'hfd, 8'hfd, 8'h04, 8'h00, 8'h00, 8'hfc, 8'h03, 8'h00, 8'hfe,
    8'hfe, 8'h02, 8'h02, 8'h07, 8'h0e};
bpm_map i_bpm_map (.clk, .rst_n, .clk_en, .density_m, .m_ok, .rd_req,
    .rd_sect, .rd_byte, .rd_busy, .rd_valid, .rd_err, .rd_data, .lk_req,
    .lk_addr, .lk_valid, .lk_err, .lk_sect, .lk_type, .lk_block,
    .lk_rd_lock, .lk_wr_bit, .lk_rd_bit, .scan_start, .scan_busy,
    .sc_valid, .sc_sect, .sc_type, .sc_count, .sc_first_bit,
    .sc_last_bit, .scan_done);
bpm_host i_bpm_host (.clk, .rd_busy, .rd_valid, .rd_err, .rd_data,
    .rd_req, .rd_sect, .rd_byte);
always #12.5 clk = ~clk;
task automatic chk(input logic [23:0] got, exp);
    n_checks++;
    if (got !== exp) begin
        error_cnt++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
        $display("No errors found");
    end else begin
        $display("Errors were found");
    end
    $finish;
endtask
function automatic logic [8:0] exp_bit(int m, logic [7:0] c);
    return (c == 8'h00) ? 9'h0 : 9'((1 << m) + 1 + int'($signed(c)));
endfunction
task automatic look(input logic [23:0] a, input logic [2:0] s,
    input logic [7:0] t, b, input logic [8:0] w, r, input logic k, er);
    lk_addr = a;
    lk_req = 1'h1;
    @(posedge clk);
    #2;
    chk({lk_valid, lk_err}, {1'h1, er});
    if (!er) begin
        chk({lk_sect, lk_type, lk_block, lk_rd_lock}, {s, t, b, k});
        chk({lk_wr_bit, lk_rd_bit}, {w, r});
    end
endtask
task automatic scan(int m);
    int s, k;
    scan_start = 1'h1;
    @(posedge clk);
    #2;
    scan_start = 1'h0;
    chk(scan_busy, 1'h1);
    i_bpm_host.read(3'h0, 2'h0, 1'h0, d, e, v);
    chk(v, 1'h0);
    i_bpm_host.idle();
    for (s = 0; s < 5; s++) begin
        k = 0;
        while (sc_valid !== 1'h1 && k < 12) begin
            @(posedge clk);
            #2;
            k++;
        end
        chk({sc_sect, sc_type}, {3'(s), tab[s*4]});
        chk(sc_count, 24'(s == 2 ? (1 << m) - 2 : 1 << tab[s*4+1]));
        chk(sc_first_bit, exp_bit(m, tab[s*4+2]));
        chk(sc_last_bit, exp_bit(m, tab[s*4+3]));
        chk(scan_done, 1'(s == 4));
        @(posedge clk);
        #2;
    end
endtask
initial begin
    repeat (5) @(posedge clk);
    #2;
    chk({rd_valid, lk_valid, scan_busy, m_ok, rd_busy}, 5'h0);
    rst_n = 1'h1;
    for (int j = 0; j < 3; j++) begin
        density_m = 4'(4 + 2 * j);
        @(posedge clk);
        #2;
        chk(m_ok, 1'h1);
        for (int i = 0; i < 20; i++) begin
            i_bpm_host.read(3'(i / 4), 2'(i % 4), 1'h1, d, e, v);
            tab[9] = 8'(4 + 2 * j);
            chk({v, e, d}, {2'h2, tab[i]});
        end
        tab[9] = 8'h00;
        i_bpm_host.read(3'h5, 2'h0, 1'h1, d, e, v);
        chk({v, e, d}, 10'h300);
        i_bpm_host.idle();
        scan(4 + 2 * j);
    end
    // lookups below are worked for the 32 Mbit layout
    density_m = 4'h6;
    look(24'h000000, 3'h0, 8'h02, 8'h00, 9'h40, 9'h41, 1'h1, 1'h0);
    look(24'h002000, 3'h0, 8'h02, 8'h01, 9'h42, 9'h43, 1'h1, 1'h0);
    look(24'h008000, 3'h1, 8'h03, 8'h00, 9'h3e, 9'h3e, 1'h0, 1'h0);
    look(24'h010000, 3'h2, 8'h04, 8'h00, 9'h00, 9'h00, 1'h0, 1'h0);
    look(24'h3effff, 3'h2, 8'h04, 8'h3d, 9'h3d, 9'h3d, 1'h0, 1'h0);
    look(24'h3f0000, 3'h3, 8'h03, 8'h00, 9'h3f, 9'h3f, 1'h0, 1'h0);
    look(24'h3f8000, 3'h4, 8'h02, 8'h00, 9'h48, 9'h49, 1'h1, 1'h0);
    look(24'h3fffff, 3'h4, 8'h02, 8'h03, 9'h4e, 9'h4f, 1'h1, 1'h0);
    // with the enable low a new address must not reach the outputs
    clk_en = 1'h0;
    lk_addr = 24'h000000;
    repeat (3) @(posedge clk);
    #2;
    chk({lk_valid, lk_wr_bit, lk_rd_bit}, {1'h1, 9'h4e, 9'h4f});
    clk_en = 1'h1;
    look(24'h400000, 3'h0, 8'h00, 8'h00, 9'h0, 9'h0, 1'h0, 1'h1);
    lk_req = 1'h0;
    density_m = 4'h3;
    @(posedge clk);
    #2;
    chk(m_ok, 1'h0);
    look(24'h000000, 3'h0, 8'h00, 8'h00, 9'h0, 9'h0, 1'h0, 1'h1);
    lk_req = 1'h0;
    give_verdict();
end
initial begin
    repeat (2000) @(posedge clk);
    error_cnt++;
    give_verdict();
end
endmodule // bpm_map_tb
